// ---- logic/smux_core.sv ----
/*
 Sample interleave transmit and receive for an eight-slot optical link and
 four AES lines. Internal side runs at the project rate, link side at single speed.
 Assumes the frame strobe comes at most once per link frame and samples are
 presented one per high-rate strobe while the link frame is open.
*/
// Function
// - In double rate mode each channel is spread over two adjacent link slots holding consecutive samples.
// - In quad rate mode each channel is spread over four link slots holding four consecutive samples.
// - Link frames faster than 48 kHz are flagged on O_FRAME_OK, not blocked; the carrier stays at single speed in every mode.
// - In quad rate mode each optical output carries only two distinct channels.
// - In double wire AES mode one line carries one channel, odd samples left and even samples right.
// - In quad wire AES mode each line carries half a channel, so one channel uses two lines.
`timescale 1ns/1ps
`default_nettype none
`include "smux_defs.svh"
module smux_core #(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic                 I_REF_CLK,
    input  wire logic                 I_ARST_N,
    // Mode
    input  wire logic [1:0]           I_MODE,
    // Internal side, eight channels, one strobe per high-rate sample
    input  wire logic                 I_SAMPLE_STB,
    input  wire logic [8*W-1:0]       I_TX_CHAN,
    // Link side frame strobe at single speed
    input  wire logic                 I_FRAME_STB,
    input  wire logic [8*W-1:0]       I_RX_SLOT,
    input  wire logic [8*W-1:0]       I_RX_AES,
    // Link outputs
    output logic      [8*W-1:0]       O_TX_SLOT,
    output logic      [8*W-1:0]       O_TX_AES,
    output logic                      O_FRAME_OK,
    // Internal outputs
    output logic      [8*W-1:0]       O_RX_CHAN,
    output logic                      O_RX_VALID
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]       phase;
        logic [8*W-1:0]   acc;
        logic [8*W-1:0]   slot;
        logic [8*W-1:0]   aes;
        logic [8*W-1:0]   rx_chan;
        logic [1:0]       rx_phase;
        logic             rx_valid;
        logic [15:0]      gap;
        logic             ok;
    } smux_state_type;

    smux_state_type          st_q;
    smux_state_type          st_d;
    smux_pkg::smux_mode_type mode;
    logic [1:0]              last_phase;
    logic [15:0]             min_gap;

    assign min_gap = 16'(`SMUX_MIN_FRAME_CYC);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        unique case (I_MODE)
            2'h1:    mode = smux_pkg::SMUX_DOUBLE;
            2'h2:    mode = smux_pkg::SMUX_QUAD;
            default: mode = smux_pkg::SMUX_SINGLE;
        endcase
        unique case (mode)
            smux_pkg::SMUX_DOUBLE: last_phase = 2'h1;
            smux_pkg::SMUX_QUAD:   last_phase = 2'h3;
            default:               last_phase = 2'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rx_valid = 1'b0;
        if (st_q.gap != 16'hffff) begin
            st_d.gap = st_q.gap + 16'h1;
        end
        // Transmit: gather consecutive samples, slot index = channel*n + phase
        if (I_SAMPLE_STB) begin
            for (int c = 0; c < 8; c++) begin
                unique case (mode)
                    smux_pkg::SMUX_DOUBLE: begin
                        if (c < 4) begin
                            st_d.acc[(2*c+st_q.phase[0])*W +: W] = I_TX_CHAN[c*W +: W];
                        end
                    end
                    smux_pkg::SMUX_QUAD: begin
                        if (c < 2) begin
                            st_d.acc[(4*c+st_q.phase)*W +: W] = I_TX_CHAN[c*W +: W];
                        end
                    end
                    default: st_d.acc[c*W +: W] = I_TX_CHAN[c*W +: W];
                endcase
            end
            st_d.phase = (st_q.phase == last_phase) ? 2'h0 : st_q.phase + 2'h1;
        end
        if (I_FRAME_STB) begin
            // Frames faster than the 48 kHz carrier are flagged, never sped up
            st_d.ok = (st_q.gap >= min_gap);
            st_d.gap = 16'h0;
            st_d.slot = st_d.acc;
            // AES lines share the optical slot layout: pair 2k/2k+1 is left/right of line k
            st_d.aes = st_d.acc;
            // Receive: slot order gives sample order, earliest first
            st_d.rx_valid = 1'b1;
            for (int c = 0; c < 8; c++) begin
                unique case (mode)
                    smux_pkg::SMUX_DOUBLE: begin
                        if (c < 4) begin
                            st_d.rx_chan[(2*c)*W +: W] = I_RX_AES[(2*c)*W +: W];
                            st_d.rx_chan[(2*c+1)*W +: W] = I_RX_SLOT[(2*c+1)*W +: W];
                        end
                    end
                    smux_pkg::SMUX_QUAD: st_d.rx_chan[c*W +: W] = I_RX_SLOT[c*W +: W];
                    default: st_d.rx_chan[c*W +: W] = I_RX_SLOT[c*W +: W];
                endcase
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_TX_SLOT  = st_q.slot;
    assign O_TX_AES   = st_q.aes;
    assign O_FRAME_OK = st_q.ok;
    assign O_RX_CHAN  = st_q.rx_chan;
    assign O_RX_VALID = st_q.rx_valid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    frame_load_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        I_FRAME_STB
        |=> O_TX_SLOT == $past(st_d.acc))
        else $error("slot load wrong");

    quad_phase_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_SAMPLE_STB && mode == smux_pkg::SMUX_QUAD && st_q.phase == 2'h3)
        |=> st_q.phase == 2'h0)
        else $error("quad phase wrap wrong");

    rate_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_FRAME_STB && st_q.gap < min_gap)
        |=> !O_FRAME_OK)
        else $error("fast frame not flagged");

    quad_order_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_SAMPLE_STB && mode == smux_pkg::SMUX_QUAD && st_q.phase == 2'h0)
        |=> st_q.acc[W-1:0] == $past(I_TX_CHAN[W-1:0]))
        else $error("quad earliest slot wrong");

    aes_copy_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        O_TX_AES == O_TX_SLOT)
        else $error("aes layout differs");

    dbl_phase_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_SAMPLE_STB && mode == smux_pkg::SMUX_DOUBLE && st_q.phase == 2'h1)
        |=> st_q.phase == 2'h0)
        else $error("double phase wrap wrong");

    rx_pulse_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        O_RX_VALID
        |=> !O_RX_VALID || $past(I_FRAME_STB))
        else $error("rx valid stuck");

    rx_order_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_FRAME_STB && mode == smux_pkg::SMUX_QUAD)
        |=> O_RX_CHAN == $past(I_RX_SLOT))
        else $error("rx order wrong");

    // Later sample of a channel lands in the upper slot of its pair
    dbl_late_slot_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_SAMPLE_STB && mode == smux_pkg::SMUX_DOUBLE && st_q.phase == 2'h1)
        |=> st_q.acc[W +: W] == $past(I_TX_CHAN[W-1:0]))
        else $error("double late slot wrong");

    quad_last_slot_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_SAMPLE_STB && mode == smux_pkg::SMUX_QUAD && st_q.phase == 2'h3)
        |=> st_q.acc[7*W +: W] == $past(I_TX_CHAN[2*W-1:W]))
        else $error("quad last slot wrong");

    quad_half_line_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_SAMPLE_STB && mode == smux_pkg::SMUX_QUAD && st_q.phase == 2'h2)
        |=> st_q.acc[2*W +: W] == $past(I_TX_CHAN[W-1:0]))
        else $error("quad second line wrong");

    rate_ok_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_FRAME_STB && st_q.gap >= min_gap)
        |=> O_FRAME_OK)
        else $error("slow frame flagged");

    // Link outputs only move once per frame, never at the sample rate
    ok_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        !I_FRAME_STB
        |=> $stable(O_FRAME_OK))
        else $error("frame flag moved between frames");

    slot_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        !I_FRAME_STB
        |=> $stable(O_TX_SLOT) && $stable(O_TX_AES))
        else $error("link slots moved between frames");

    rx_even_aes_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        (I_FRAME_STB && mode == smux_pkg::SMUX_DOUBLE)
        |=> O_RX_CHAN[W-1:0] == $past(I_RX_AES[W-1:0]))
        else $error("double rx left subframe wrong");

    rx_strobe_a: assert property (@(posedge I_REF_CLK) disable iff (!I_ARST_N)
        I_FRAME_STB
        |=> O_RX_VALID)
        else $error("rx valid missing");
endmodule : smux_core
`default_nettype wire

// ---- logic/smux_defs.svh ----
/*
 Timing constants for the sample interleave block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef SMUX_DEFS_SVH
`define SMUX_DEFS_SVH
// ------------------------------------------------------------
// Carrier limits
// ------------------------------------------------------------
`define SMUX_CARRIER_MAX_HZ 48000
`define SMUX_CARRIER_LOW_HZ 44100
`define SMUX_REF_CLK_HZ     40000000
// Least reference cycles per link frame at the highest carrier
`define SMUX_MIN_FRAME_CYC  ((`SMUX_REF_CLK_HZ + `SMUX_CARRIER_MAX_HZ - 1) / `SMUX_CARRIER_MAX_HZ)
`endif

// ---- logic/smux_pkg.sv ----
/*
 Types for the sample interleave block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package smux_pkg;
    typedef enum logic [1:0] {
        SMUX_SINGLE,
        SMUX_DOUBLE,
        SMUX_QUAD
    } smux_mode_type;
endpackage : smux_pkg
`default_nettype wire

// ---- dv/smux_far_end.sv ----
/*
 Far-end link model: frame strobe plus received optical and AES slots.
 Assumes the bench calls send_frame once per link frame.
*/
`timescale 1ns/1ps
`default_nettype none
module smux_far_end #(
    parameter int W = 24
) (
    input  wire logic           i_clk,
    output logic                o_stb,
    output logic [8*W-1:0]      o_slot,
    output logic [8*W-1:0]      o_aes
);
    logic [8*W-1:0] sent_slot;
    logic [8*W-1:0] sent_aes;
    initial begin
        o_stb = 1'b0;
        o_slot = '0;
        o_aes = '1;
    end
    // Data is held for the strobe cycle only
    task automatic send_frame();
        @(negedge i_clk);
        o_stb = 1'b1;
        for (int s = 0; s < 8; s++) begin
            o_slot[s*W +: W] = W'($urandom);
            o_aes[s*W +: W] = W'($urandom);
        end
        sent_slot = o_slot;
        sent_aes = o_aes;
        @(negedge i_clk);
        o_stb = 1'b0;
        // Inverted so stale data can never pass for fresh
        o_slot = ~o_slot;
        o_aes = ~o_aes;
    endtask : send_frame
endmodule : smux_far_end
`default_nettype wire

// ---- dv/sample_multiplex_tx_rx_tb.sv ----
/*
 Self-checking bench for smux_core against a far-end link model.
 Assumes the core's registered one-cycle answer after each frame strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_multiplex_tx_rx_tb;
    localparam int W = 24;
    logic           clk = 1'b0;
    logic           arst_n = 1'b0;
    logic           sample_stb = 1'b0;
    logic [1:0]     mode = 2'h0;
    logic [8*W-1:0] tx_chan = '0;
    logic [8*W-1:0] rx_slot, rx_aes, tx_slot, tx_aes, rx_chan;
    logic           frame_stb, frame_ok, rx_valid;
    logic [8*W-1:0] smp [4];
    logic [1:0]     mtab [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    int             fail_count = 0;
    int             cmp_count = 0;
    smux_core #(.W(W)) u_smux_core (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_MODE(mode),
        .I_SAMPLE_STB(sample_stb), .I_TX_CHAN(tx_chan), .I_FRAME_STB(frame_stb), .I_RX_SLOT(rx_slot),
        .I_RX_AES(rx_aes), .O_TX_SLOT(tx_slot), .O_TX_AES(tx_aes), .O_FRAME_OK(frame_ok),
        .O_RX_CHAN(rx_chan), .O_RX_VALID(rx_valid));
    smux_far_end #(.W(W)) u_smux_far_end (.i_clk(clk), .o_stb(frame_stb), .o_slot(rx_slot), .o_aes(rx_aes));
    function automatic logic [8*W-1:0] exp_tx(input logic [1:0] m);
        logic [8*W-1:0] r;
        r = smp[0];
        for (int s = 0; s < 8; s++) begin
            if (m == smux_pkg::SMUX_DOUBLE) r[s*W +: W] = smp[s%2][(s/2)*W +: W];
            else if (m == smux_pkg::SMUX_QUAD) r[s*W +: W] = smp[s%4][(s/4)*W +: W];
        end
        return r;
    endfunction : exp_tx
    function automatic logic [8*W-1:0] exp_rx(input logic [1:0] m);
        logic [8*W-1:0] r;
        r = u_smux_far_end.sent_slot;
        for (int s = 0; s < 8; s += 2) begin
            if (m == smux_pkg::SMUX_DOUBLE) r[s*W +: W] = u_smux_far_end.sent_aes[s*W +: W];
        end
        return r;
    endfunction : exp_rx
    task automatic check(input logic [8*W-1:0] got, input logic [8*W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : check
    // Samples first, then the frame strobe gap+1 cycles after the previous frame strobe
    task automatic frame(input logic [1:0] m, input int gap, input logic chk_ok);
        int k;
        k = (m == 2'h1) ? 2 : (m == 2'h2) ? 4 : 1;
        mode = m;
        for (int i = 0; i < k; i++) begin
            for (int c = 0; c < 8; c++) begin
                smp[i][c*W +: W] = W'($urandom);
            end
            sample_stb = 1'b1;
            tx_chan = smp[i];
            @(negedge clk);
        end
        sample_stb = 1'b0;
        repeat (gap - 2 - k) @(negedge clk);
        u_smux_far_end.send_frame();
        check(tx_slot, exp_tx(m));
        check(tx_aes, exp_tx(m));
        check(rx_chan, exp_rx(m));
        check(rx_valid, 1'b1);
        if (chk_ok) check(frame_ok, gap >= 834);
        @(negedge clk);
        check(rx_valid, 1'b0);
    endtask : frame
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        void'($urandom(27));
        repeat (10) @(negedge clk);
        check(tx_slot | tx_aes | rx_chan, '0);
        check({frame_ok, rx_valid}, '0);
        arst_n = 1'b1;
        @(negedge clk);
        for (int i = 0; i < 12; i++) begin
            frame(mtab[i%4], (i == 1) ? 834 : (i == 2) ? 833 : 834 + int'($urandom % 40), i > 0);
        end
        report_and_stop();
    end
    // Twelve frames of under 900 cycles each fit well inside this span
    initial begin
        #(25 * 20000);
        fail_count++;
        report_and_stop();
    end
endmodule : sample_multiplex_tx_rx_tb
`default_nettype wire
